/* File: spxo_params.svh */
// Constants for the extended pointer and call instruction unit.
`ifndef SPXO_PARAMS_SVH
`define SPXO_PARAMS_SVH
`define SPXO_ADDPTR_OPC   8'he8
`define SPXO_COMPUTED_CALL_VIA_WORKING_REG_WORD   16'h0014
`define SPXO_SEL_STACK    2'h3
`define SPXO_SEL_STACKPTR 2'h2
`define SPXO_RET_OFFSET   21'h000002
`define SPXO_PTR_RESET    12'h000
`endif

/* File: spxo_pkg.sv */
// Types for the extended pointer and call instruction unit.
package spxo_pkg;
    typedef enum logic [1:0]
    {
        SPXO_EXEC = 2'h1,
        SPXO_NOP  = 2'h2
    } spxo_state_e;
    typedef logic [20:0] spxo_pc_t;
    typedef logic [11:0] spxo_ptr_t;
endpackage : spxo_pkg

/* File: spxo_ptr_if.sv */
// Port group between the top unit and its pointer file.
interface spxo_ptr_if;
    import spxo_pkg::*;
    logic      wr_en;
    logic [1:0] wr_sel;
    spxo_ptr_t wr_data;
    spxo_ptr_t ptr0;
    spxo_ptr_t ptr1;
    spxo_ptr_t ptr2;
    modport owner (input wr_en, input wr_sel, input wr_data, output ptr0, output ptr1, output ptr2);
    modport user  (output wr_en, output wr_sel, output wr_data, input ptr0, input ptr1, input ptr2);
endinterface : spxo_ptr_if

/* File: spxo_ptr_file.sv */
// Three pointer registers with one write port.
`include "spxo_params.svh"
module spxo_ptr_file
    import spxo_pkg::*;
(
    input  wire logic  ref_clk,
    input  wire logic  reset,
    spxo_ptr_if.owner  pif
);
    spxo_ptr_t ptr_r   [3];
    spxo_ptr_t ptr_nxt [3];

    // Each pointer loads only when selected; selection 3 never reaches here with the write enable high.
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_ptr
            always_comb
            begin
                ptr_nxt[gi] = ptr_r[gi];
                if (pif.wr_en && (pif.wr_sel == 2'(gi)))
                    ptr_nxt[gi] = pif.wr_data;
            end
            always_ff @(posedge ref_clk)
            begin
                if (reset)
                    ptr_r[gi] <= `SPXO_PTR_RESET;
                else
                    ptr_r[gi] <= ptr_nxt[gi];
            end
        end
    endgenerate

    assign pif.ptr0 = ptr_r[0];
    assign pif.ptr1 = ptr_r[1];
    assign pif.ptr2 = ptr_r[2];
endmodule : spxo_ptr_file

/* File: spxo_ext_exec.sv */
// Execution unit for the pointer add, add-and-return and computed call instructions.
// Notes on behaviour
// [RULE_01] Extended instructions decode only while the extended set enable is high.
// [RULE_02] Pointer add is 1110 1000 ffkk kkkk; computed call is 0x0014.
// [RULE_03] Pointer add adds unsigned six-bit literal to pointer 0, 1 or 2.
// [RULE_04] Select value 3 means add-and-return on the software stack pointer.
// [RULE_05] Add-and-return adds the six-bit literal to the software stack pointer.
// [RULE_06] Add-and-return then loads the program counter from the return stack top.
// [RULE_07] Add-and-return takes two cycles; the second does nothing.
// [RULE_08] Computed call pushes program counter plus two onto the return stack.
// [RULE_09] Computed call writes the working register into the program counter low byte.
// [RULE_10] Computed call loads high and upper bytes from their latches.
// [RULE_11] Computed call spends a second, idle cycle fetching the new target.
// [RULE_12] Computed call makes no shadow save of working, status or bank registers.
// [RULE_13] All three leave status flags alone; pointer add is one word, one cycle.
`include "spxo_params.svh"
module spxo_ext_exec
    import spxo_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic        extended_set_enable,
    input  wire logic        instr_valid,
    input  wire logic [15:0] instr_word,
    input  wire spxo_pc_t    pc_current,
    input  wire logic [7:0]  working_register,
    input  wire logic [7:0]  pc_high_latch,
    input  wire logic [7:0]  pc_upper_latch,
    input  wire spxo_pc_t    top_of_return_stack,
    output logic             instr_accept,
    output logic             busy,
    output logic             pc_load,
    output spxo_pc_t         pc_load_value,
    output logic             stack_push,
    output spxo_pc_t         stack_push_value,
    output logic             stack_pop,
    output logic             shadow_save,
    output logic             status_write,
    output spxo_ptr_t        file_select_pointer_0,
    output spxo_ptr_t        file_select_pointer_1,
    output spxo_ptr_t        software_stack_pointer
);
    spxo_state_e state_r;
    spxo_state_e state_nxt;
    logic        pc_load_r;
    logic        pc_load_nxt;
    spxo_pc_t    pc_value_r;
    spxo_pc_t    pc_value_nxt;
    logic        push_r;
    logic        push_nxt;
    spxo_pc_t    push_val_r;
    spxo_pc_t    push_val_nxt;
    logic        pop_r;
    logic        pop_nxt;
    logic        is_add;
    logic        is_ret;
    logic        is_call;
    logic [5:0]  lit;

    spxo_ptr_if pif ();

    spxo_ptr_file u_ptr_file
    (
        .ref_clk (ref_clk),
        .reset   (reset),
        .pif     (pif)
    );

    // Decode only in the first cycle of an instruction, so a word seen during the idle
    // second cycle is dropped here and no later stage has to filter it out again.
    // [RULE_01] enable gated decode
    // [RULE_02] opcode pattern match
    always_comb
    begin
        lit     = instr_word[5:0];
        is_add  = extended_set_enable && instr_valid && (state_r == SPXO_EXEC)
                  && (instr_word[15:8] == `SPXO_ADDPTR_OPC);
        is_ret  = is_add && (instr_word[7:6] == `SPXO_SEL_STACK);
        is_call = extended_set_enable && instr_valid && (state_r == SPXO_EXEC)
                  && (instr_word == `SPXO_COMPUTED_CALL_VIA_WORKING_REG_WORD);
    end

    // Pointer write port: selection 3 is redirected to the stack pointer.
    // The sum wraps at twelve bits; a carry out is dropped, as the pointer has no wider form.
    // [RULE_03] literal add to pointer
    // [RULE_05] literal add to stack pointer
    always_comb
    begin
        pif.wr_en   = is_add;
        pif.wr_sel  = is_ret ? `SPXO_SEL_STACKPTR : instr_word[7:6];
        case (pif.wr_sel)
            2'h0:    pif.wr_data = pif.ptr0 + {6'h00, lit};
            2'h1:    pif.wr_data = pif.ptr1 + {6'h00, lit};
            default: pif.wr_data = pif.ptr2 + {6'h00, lit};
        endcase
    end

    // Sequencer plus program counter and return stack requests.
    // [RULE_04] select 3 becomes return
    // [RULE_07] two cycle return
    // [RULE_11] idle fetch cycle
    always_comb
    begin
        state_nxt    = SPXO_EXEC;
        pc_load_nxt  = 1'b0;
        pc_value_nxt = pc_value_r;
        push_nxt     = 1'b0;
        push_val_nxt = push_val_r;
        pop_nxt      = 1'b0;
        case (state_r)
            SPXO_EXEC:
            begin
                if (is_ret)
                begin
                    // [RULE_06] return from stack
                    state_nxt    = SPXO_NOP;
                    pc_load_nxt  = 1'b1;
                    pc_value_nxt = top_of_return_stack;
                    pop_nxt      = 1'b1;
                end
                else if (is_call)
                begin
                    // [RULE_08] push return address
                    // [RULE_09] working reg to low byte
                    // [RULE_10] latches to high bytes
                    state_nxt    = SPXO_NOP;
                    push_nxt     = 1'b1;
                    push_val_nxt = pc_current + `SPXO_RET_OFFSET;
                    pc_load_nxt  = 1'b1;
                    pc_value_nxt = {pc_upper_latch[4:0], pc_high_latch, working_register};
                end
            end
            SPXO_NOP:
                state_nxt = SPXO_EXEC;
            default:
                state_nxt = SPXO_EXEC;
        endcase
    end

    // Registered requests so the core sees them at the cycle boundary.
    // Registering costs a cycle of latency but keeps decode logic out of the core's load path.
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            state_r    <= SPXO_EXEC;
            pc_load_r  <= 1'b0;
            pc_value_r <= 21'h000000;
            push_r     <= 1'b0;
            push_val_r <= 21'h000000;
            pop_r      <= 1'b0;
        end
        else
        begin
            state_r    <= state_nxt;
            pc_load_r  <= pc_load_nxt;
            pc_value_r <= pc_value_nxt;
            push_r     <= push_nxt;
            push_val_r <= push_val_nxt;
            pop_r      <= pop_nxt;
        end
    end

    // Outputs; the busy cycle is the idle second cycle.
    // Shadow and status strobes are tied low, as none of these instructions may touch them.
    // [RULE_12] no shadow save
    // [RULE_13] flags untouched
    assign instr_accept           = (state_r == SPXO_EXEC);
    assign busy                   = (state_r == SPXO_NOP);
    assign pc_load                = pc_load_r;
    assign pc_load_value          = pc_value_r;
    assign stack_push             = push_r;
    assign stack_push_value       = push_val_r;
    assign stack_pop              = pop_r;
    assign shadow_save            = 1'b0;
    assign status_write           = 1'b0;
    assign file_select_pointer_0  = pif.ptr0;
    assign file_select_pointer_1  = pif.ptr1;
    assign software_stack_pointer = pif.ptr2;

    // Assertions on sequencing and results.
    a_ptr_add_sum: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_03]
        (is_add && !is_ret && instr_word[7:6] == 2'h0) |=>
        file_select_pointer_0 == $past(file_select_pointer_0) + {6'h00, $past(lit)})
        else $error("pointer add sum wrong");
    a_ret_stack_add: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_05]
        is_ret |=> software_stack_pointer == $past(software_stack_pointer) + {6'h00, $past(lit)})
        else $error("stack pointer add wrong");
    a_ret_pc_load: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_06]
        is_ret |=> pc_load && stack_pop && pc_load_value == $past(top_of_return_stack))
        else $error("return did not load pc");
    a_ret_two_cycle: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_07]
        is_ret |=> busy ##1 !busy)
        else $error("return not two cycles");
    a_call_push_val: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_08]
        is_call |=> stack_push && stack_push_value == $past(pc_current) + 21'h000002)
        else $error("call push wrong");
    a_call_target: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_10]
        is_call |=> pc_load_value == {$past(pc_upper_latch[4:0]), $past(pc_high_latch),
                                      $past(working_register)})
        else $error("call target wrong");
    a_disabled_idle: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_01]
        !extended_set_enable |=> !pc_load && !stack_push)
        else $error("decode while disabled");
    a_add_one_cycle: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_13]
        (is_add && !is_ret) |=> !busy && !pc_load && !status_write)
        else $error("pointer add not single cycle");
    c_ptr_add: cover property (@(posedge ref_clk) is_add && !is_ret);
    c_ret: cover property (@(posedge ref_clk) is_ret);
    c_call: cover property (@(posedge ref_clk) is_call);
    c_disabled_call: cover property (@(posedge ref_clk)
        !extended_set_enable && instr_valid && instr_word == 16'h0014);
    c_call_then_ret: cover property (@(posedge ref_clk) is_call ##2 is_ret);

    // Decode checks taken from the raw word, so a wrong pattern constant shows up here.
    // [RULE_02] call word decode.
    a_call_decode: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_02]
        (extended_set_enable && instr_valid && instr_accept && instr_word == 16'h0014)
        |=> stack_push && pc_load && busy)
        else $error("call word not decoded");

    // [RULE_02] pointer add decode.
    a_add_decode: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_02]
        (extended_set_enable && instr_valid && instr_accept && instr_word[15:6] == 10'h3a1)
        |=> file_select_pointer_1 ==
            $past(file_select_pointer_1) + {6'h00, $past(instr_word[5:0])})
        else $error("pointer add word not decoded");

    // Pointers that the word does not select must keep their value.
    // [RULE_03] other pointers kept.
    a_add_ptr_one: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_03]
        (is_add && !is_ret && instr_word[7:6] == 2'h1) |=>
        $stable(file_select_pointer_0) && $stable(software_stack_pointer))
        else $error("pointer add touched another pointer");

    // [RULE_03] third pointer sum.
    a_add_ptr_two: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_03]
        (is_add && !is_ret && instr_word[7:6] == 2'h2) |=>
        software_stack_pointer == $past(software_stack_pointer) + {6'h00, $past(lit)}
        && $stable(file_select_pointer_0) && $stable(file_select_pointer_1))
        else $error("third pointer add wrong");

    // [RULE_04] return spares others.
    a_ret_sel_stack: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_04]
        is_ret |=> $stable(file_select_pointer_0) && $stable(file_select_pointer_1))
        else $error("return wrote a plain pointer");

    // [RULE_06] return never pushes.
    a_ret_no_push: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_06]
        is_ret |=> !stack_push)
        else $error("return pushed the stack");

    // The idle second cycle must refuse whatever word stands at the input.
    // [RULE_07] idle cycle refuses.
    a_busy_refuse: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_07]
        busy |=> !pc_load && !stack_push && !stack_pop
        && $stable(file_select_pointer_0) && $stable(software_stack_pointer))
        else $error("word taken in idle cycle");

    // [RULE_07] load pulse single.
    a_load_single: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_07]
        pc_load |=> !pc_load)
        else $error("program counter load held");

    // [RULE_08] push pulse single.
    a_push_single: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_08]
        stack_push |=> !stack_push)
        else $error("return stack push held");

    // [RULE_08] call never pops.
    a_call_no_pop: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_08]
        is_call |=> !stack_pop && $stable(software_stack_pointer))
        else $error("call popped or moved stack pointer");

    // [RULE_09] low byte from working.
    a_call_low_byte: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_09]
        is_call |=> pc_load && pc_load_value[7:0] == $past(working_register))
        else $error("call low byte wrong");

    // [RULE_11] idle fetch cycle.
    a_call_idle: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_11]
        is_call |=> busy ##1 (!busy && !pc_load && !stack_push))
        else $error("call idle cycle wrong");

    // [RULE_12] no shadow save.
    a_call_no_shadow: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_12]
        is_call |=> !shadow_save ##1 !shadow_save)
        else $error("call saved shadow copies");

    // [RULE_13] flags left alone.
    a_flags_kept: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_13]
        (is_call || is_ret) |=> !status_write ##1 !status_write)
        else $error("status flags written");

    // A word that is switched off or not valid must leave every output quiet.
    // [RULE_01] disabled keeps pointers.
    a_disabled_ptr: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_01]
        !extended_set_enable |=> $stable(file_select_pointer_0)
        && $stable(file_select_pointer_1) && $stable(software_stack_pointer))
        else $error("pointer moved while disabled");

    // [RULE_01] invalid word ignored.
    a_invalid_idle: assert property (@(posedge ref_clk) disable iff (reset) // [RULE_01]
        !instr_valid |=> !pc_load && !stack_push && !stack_pop)
        else $error("invalid word executed");
endmodule : spxo_ext_exec

/* File: spxo_core_model.sv */
// Behavioural model of the core program counter and hardware return stack.
module spxo_core_model
    import spxo_pkg::*;
(
    input  wire logic     ref_clk,
    input  wire logic     reset,
    input  wire logic     pc_load,
    input  wire spxo_pc_t pc_load_value,
    input  wire logic     stack_push,
    input  wire spxo_pc_t stack_push_value,
    input  wire logic     stack_pop,
    output spxo_pc_t      pc_current,
    output spxo_pc_t      top_of_return_stack
);
    timeunit 1ns;
    timeprecision 1ps;
    spxo_pc_t   stk [32];
    logic [4:0] sp;
    // An empty stack shows a moving pattern so a stale top is never trusted.
    assign top_of_return_stack = (sp != 5'h00) ? stk[sp - 5'h01] : ~pc_current;
    // The counter steps one word a cycle unless the unit loads it.
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            pc_current <= 21'h000000;
            sp <= 5'h00;
        end
        else
        begin
            pc_current <= pc_load ? pc_load_value : pc_current + 21'h000002;
            if (stack_push)
                stk[sp] <= stack_push_value;
            sp <= sp + 5'(stack_push) - 5'(stack_pop && sp != 5'h00);
        end
    end
endmodule : spxo_core_model

/* File: stack_pointer_extended_ops_tb.sv */
// Self-checking random bench for the extended pointer and call unit.
module stack_pointer_extended_ops_tb
    import spxo_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, reset, extended_set_enable, instr_valid, instr_accept, busy;
    logic pc_load, stack_push, stack_pop, shadow_save, status_write;
    logic [15:0] instr_word, w;
    logic [7:0] working_register, pc_high_latch, pc_upper_latch;
    spxo_pc_t pc_current, top_of_return_stack, pc_load_value, stack_push_value, e_lv, e_pv;
    spxo_ptr_t fsp0, fsp1, ssp;
    spxo_ptr_t p [3];
    logic [31:0] x;
    logic en, vld, acc, ptr, call, ret, e_load, e_push, e_pop, e_busy;
    int n_fail, total_checks;
    spxo_ext_exec u_spxo_ext_exec (.ref_clk(ref_clk), .reset(reset),
        .extended_set_enable(extended_set_enable), .instr_valid(instr_valid),
        .instr_word(instr_word), .pc_current(pc_current), .working_register(working_register),
        .pc_high_latch(pc_high_latch), .pc_upper_latch(pc_upper_latch),
        .top_of_return_stack(top_of_return_stack), .instr_accept(instr_accept), .busy(busy),
        .pc_load(pc_load), .pc_load_value(pc_load_value), .stack_push(stack_push),
        .stack_push_value(stack_push_value), .stack_pop(stack_pop), .shadow_save(shadow_save),
        .status_write(status_write), .file_select_pointer_0(fsp0),
        .file_select_pointer_1(fsp1), .software_stack_pointer(ssp));
    spxo_core_model u_spxo_core_model (.ref_clk(ref_clk), .reset(reset), .pc_load(pc_load),
        .pc_load_value(pc_load_value), .stack_push(stack_push),
        .stack_push_value(stack_push_value), .stack_pop(stack_pop), .pc_current(pc_current),
        .top_of_return_stack(top_of_return_stack));
    // A 25 ns period gives the 40 MHz core clock.
    always #12.5 ref_clk = ~ref_clk;
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction : xs
    task automatic chk(input logic [20:0] got, input logic [20:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic complete_run;
        $display("checks=%0d failures=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run
    // Early cycles walk the stack pointer past its wrap; later ones mix all cases.
    initial
    begin
        {ref_clk, extended_set_enable, instr_valid, instr_word} = '0;
        {working_register, pc_high_latch, pc_upper_latch} = '0;
        {e_load, e_push, e_pop, e_busy, e_lv, e_pv} = '0;
        p = '{default: 12'h000};
        reset = 1'b1;
        x = 32'h79e5;
        n_fail = 0;
        total_checks = 0;
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        for (int i = 0; i < 700; i++)
        begin
            @(posedge ref_clk);
            x = xs(x);
            w = (x[2:0] == 3'h4) ? 16'h0014 : (x[2:0] == 3'h5) ? x[31:16] : {8'he8, x[15:8]};
            if (i < 200)
                w = (i % 7 == 6) ? 16'he8ff : {8'he8, 2'(i % 3), 6'h3f};
            // Now and then a call word arrives while the set is off or the word is not valid.
            en = (x[2:0] != 3'h6) && !(x[2:0] == 3'h4 && x[5:3] == 3'h0) || i < 200;
            vld = (x[2:0] != 3'h7) && !(x[2:0] == 3'h4 && x[5:3] == 3'h1) || i < 200;
            instr_word <= w;
            extended_set_enable <= en;
            instr_valid <= vld;
            {pc_upper_latch, pc_high_latch, working_register} <= x[31:8];
            #1;
            chk(21'(fsp0), 21'(p[0]));
            chk(21'(fsp1), 21'(p[1]));
            chk(21'(ssp), 21'(p[2]));
            chk(21'(stack_pop), 21'(e_pop));
            chk(21'(busy), 21'(e_busy));
            chk(21'(instr_accept), 21'(!e_busy));
            chk(21'(stack_push), 21'(e_push));
            chk(21'(pc_load), 21'(e_load));
            chk(21'({shadow_save, status_write}), 21'h0);
            if (e_push)
                chk(stack_push_value, e_pv);
            if (e_load)
                chk(pc_load_value, e_lv);
            // Work out what the word just driven must do at the next edge.
            acc = vld && en && !e_busy;
            ptr = acc && w[15:8] == 8'he8;
            call = acc && w == 16'h0014;
            ret = ptr && w[7:6] == 2'h3;
            if (ptr)
                p[(w[7:6] == 2'h3) ? 2'h2 : w[7:6]] += 12'(w[5:0]);
            e_lv = ret ? top_of_return_stack : {pc_upper_latch[4:0], pc_high_latch,
                working_register};
            e_pv = pc_current + 21'h000002;
            {e_pop, e_push, e_load, e_busy} = {ret, call, ret || call, ret || call};
        end
        complete_run();
    end
endmodule : stack_pointer_extended_ops_tb
